// [rtl/mtd_decoder.v]
// Manchester telegram decoder with APB configuration, wake control and serial output.
// Assumes demodulated data and wake pin synchronous to clk_i.
`timescale 1ns/1ns
`include "mtd_regs.vh"
module mtd_decoder #(
    parameter TSTROBE_CYC = `MTD_TSTROBE_CYC
) (
    // Clock and reset.
    input wire clk_i,
    input wire rst_n_i,
    // APB slave.
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    // Receiver pins.
    input wire demod_output_pin_i,
    input wire wake_pin_i,
    input wire config_mode_pin_i,
    // Serial output and run status.
    output reg mosi_o,
    output reg sclk_o,
    output reg run_mode_o
);
    localparam S_SRCH = 4'h1;
    localparam S_HDR = 4'h2;
    localparam S_DATA = 4'h4;
    localparam [15:0] TSTROBE_LAST = TSTROBE_CYC - 1;

    reg [7:0] cfg1;
    reg [7:0] cfg2;
    reg [15:0] half_cyc;
    reg [3:0] state;
    reg [3:0] next_state;
    reg [15:0] tmr;
    reg pos;
    reg prev_in;
    reg first_half;
    reg viol_prev;
    reg nrz_run;
    reg [7:0] id_sh;
    reg [3:0] hdr_sh;
    reg invert;
    reg next_invert;
    reg [7:0] out_sh;
    reg [2:0] out_cnt;
    reg load_req;
    reg [7:0] load_byte;
    reg [7:0] tx_sh;
    reg [3:0] slot;
    reg busy;
    reg [15:0] sck_tmr;
    reg [5:0] slot_cnt;
    reg id_seen;
    reg [31:0] prd;
    reg [15:0] eom_count;

    wire data_manager_enable = cfg1[`MTD_BIT_DATA_MGR];
    wire header_mode = cfg1[`MTD_BIT_HDR];
    wire soe = cfg1[`MTD_BIT_SOE];
    wire [1:0] sr_sel = {cfg1[`MTD_BIT_SR1], cfg1[`MTD_BIT_SR0]};
    // Strobe ratio is 3, 7, 15 or 31 sleep periods per run period.
    wire [5:0] sr_ratio = (6'h04 << sr_sel) - 6'h01;
    wire edge_seen = demod_output_pin_i != prev_in;
    wire [15:0] quarter = half_cyc >> 1;
    wire half_tick = edge_seen | (tmr == half_cyc - 16'h0001);
    wire sample_tick = tmr == quarter;
    wire pair_viol = sample_tick & pos & (first_half == demod_output_pin_i);
    wire pair_resync = sample_tick & pos & ~pair_viol & nrz_run & (state == S_SRCH);
    wire bit_ok = sample_tick & pos & ~pair_viol & ~pair_resync;
    wire bit_val = first_half;
    wire eom_seen = pair_viol & ((state == S_HDR) | (state == S_DATA));
    wire [3:0] hdr_next = {hdr_sh[2:0], bit_val};
    wire [7:0] id_next = {id_sh[6:0], bit_val};
    wire apb_wr = psel_i & penable_i & pwrite_i;

    function [0:0] sel_match;
        input [7:0] a;
        input [7:0] b;
        begin
            sel_match = (a == b) | (a == ~b);
        end
    endfunction

    function [0:0] hdr_match;
        input [3:0] w;
        input inv;
        begin
            hdr_match = inv ? (w == ~`MTD_HDR_WORD) : (w == `MTD_HDR_WORD);
        end
    endfunction

    assign pready_o = 1'b1;
    assign pslverr_o = 1'b0;
    assign prdata_o = prd;

    // Configuration survives sleep because nothing here clears it but reset.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg1 <= `MTD_CFG1_RESET;
            cfg2 <= `MTD_CFG2_RESET;
            half_cyc <= `MTD_RATE_RESET;
        end else if (apb_wr) begin
            case (paddr_i)
                `MTD_ADDR_CFG1: cfg1 <= pwdata_i[7:0];
                `MTD_ADDR_CFG2: cfg2 <= pwdata_i[7:0];
                `MTD_ADDR_RATE: half_cyc <= (pwdata_i[15:0] < 16'h0004) ? 16'h0004 : pwdata_i[15:0];
                default: cfg1 <= cfg1;
            endcase
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prd <= 32'h0000_0000;
        end else if (psel_i & ~penable_i & ~pwrite_i) begin
            case (paddr_i)
                `MTD_ADDR_CFG1: prd <= {24'h000000, cfg1};
                `MTD_ADDR_CFG2: prd <= {24'h000000, cfg2};
                `MTD_ADDR_RATE: prd <= {16'h0000, half_cyc};
                `MTD_ADDR_STAT: prd <= {eom_count, 8'h00, state, invert, id_seen, run_mode_o, 1'b0};
                default: prd <= 32'h0000_0000;
            endcase
        end
    end

    // Strobe timer: one run slot out of every ratio plus one periods.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_tmr <= 16'h0000;
            slot_cnt <= 6'h00;
        end else if (sck_tmr >= TSTROBE_LAST) begin
            sck_tmr <= 16'h0000;
            slot_cnt <= (slot_cnt >= sr_ratio) ? 6'h00 : slot_cnt + 6'h01;
        end else begin
            sck_tmr <= sck_tmr + 16'h0001;
        end
    end

    // Run/sleep control: the wake pin wins, a seen ID extends the run slot.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_mode_o <= 1'b1;
        end else if (wake_pin_i) begin
            run_mode_o <= 1'b1;
        end else if (soe) begin
            run_mode_o <= (slot_cnt == 6'h00) | (data_manager_enable & id_seen);
        end else begin
            run_mode_o <= 1'b0;
        end
    end

    // Half-bit timer: restarts on every line edge so sampling tracks the sender.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_in <= 1'b0;
            tmr <= 16'h0000;
        end else begin
            prev_in <= demod_output_pin_i;
            if (half_tick) begin
                tmr <= 16'h0000;
            end else begin
                tmr <= tmr + 16'h0001;
            end
        end
    end

    // Half-bit pairing: equal halves realign, the first change after a steady level starts a bit.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_half <= 1'b0;
            pos <= 1'b0;
            viol_prev <= 1'b0;
            nrz_run <= 1'b0;
        end else if (sample_tick) begin
            if (!pos) begin
                first_half <= demod_output_pin_i;
                pos <= 1'b1;
            end else if (pair_viol) begin
                first_half <= demod_output_pin_i;
                nrz_run <= viol_prev;
                viol_prev <= 1'b1;
            end else if (pair_resync) begin
                first_half <= demod_output_pin_i;
                nrz_run <= 1'b0;
                viol_prev <= 1'b0;
            end else begin
                pos <= 1'b0;
                nrz_run <= 1'b0;
                viol_prev <= 1'b0;
            end
        end
    end

    // Frame sequencer: search for the ID, then the header when header mode is set, then data.
    always @* begin
        next_state = state;
        next_invert = invert;
        case (state)
            S_SRCH: begin
                if (bit_ok && sel_match(id_next, cfg2)) begin
                    next_state = header_mode ? S_HDR : S_DATA;
                    next_invert = 1'b0;
                end
            end
            S_HDR: begin
                if (eom_seen) begin
                    next_state = S_SRCH;
                end else if (bit_ok && hdr_match(hdr_next, 1'b0)) begin
                    next_state = S_DATA;
                    next_invert = 1'b0;
                end else if (bit_ok && hdr_match(hdr_next, 1'b1)) begin
                    next_state = S_DATA;
                    next_invert = 1'b1;
                end
            end
            S_DATA: begin
                if (eom_seen) begin
                    next_state = S_SRCH;
                    next_invert = 1'b0;
                end
            end
            default: begin
                next_state = S_SRCH;
                next_invert = 1'b0;
            end
        endcase
        if (!data_manager_enable) begin
            next_state = S_SRCH;
            next_invert = 1'b0;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= S_SRCH;
            invert <= 1'b0;
        end else begin
            state <= next_state;
            invert <= next_invert;
        end
    end

    // Search shifters: ID bits while searching, header bits after a matched ID.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            id_sh <= 8'h00;
            hdr_sh <= 4'h0;
        end else if (bit_ok) begin
            if (state == S_SRCH) begin
                id_sh <= id_next;
                hdr_sh <= 4'h0;
            end else if (state == S_HDR) begin
                hdr_sh <= hdr_next;
            end
        end
    end

    // ID flag and end-of-message counter.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            id_seen <= 1'b0;
            eom_count <= 16'h0000;
        end else begin
            if (!data_manager_enable || eom_seen) begin
                id_seen <= 1'b0;
            end else if (state == S_SRCH && next_state != S_SRCH) begin
                id_seen <= 1'b1;
            end
            if (eom_seen) begin
                eom_count <= eom_count + 16'h0001;
            end
        end
    end

    // Data assembly: whole bytes go out at once, a partial byte is padded with zeros.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_sh <= 8'h00;
            out_cnt <= 3'h0;
            load_req <= 1'b0;
            load_byte <= 8'h00;
        end else begin
            load_req <= 1'b0;
            if (state != S_DATA) begin
                out_cnt <= 3'h0;
            end else if (eom_seen) begin
                out_cnt <= 3'h0;
                if (out_cnt != 3'h0) begin
                    load_req <= 1'b1;
                    load_byte <= out_sh << (4'h8 - {1'b0, out_cnt});
                end
            end else if (bit_ok) begin
                out_sh <= {out_sh[6:0], bit_val ^ invert};
                out_cnt <= out_cnt + 3'h1;
                if (out_cnt == 3'h7) begin
                    load_req <= 1'b1;
                    load_byte <= {out_sh[6:0], bit_val ^ invert};
                end
            end
        end
    end

    // Serial master: each loaded byte leaves MSB first over sixteen half-bit ticks.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_sh <= 8'h00;
            slot <= 4'h0;
            busy <= 1'b0;
            mosi_o <= 1'b0;
            sclk_o <= 1'b0;
        end else if (!data_manager_enable) begin
            busy <= 1'b0;
            slot <= 4'h0;
            sclk_o <= 1'b0;
            mosi_o <= demod_output_pin_i;
        end else if (!config_mode_pin_i) begin
            busy <= 1'b0;
            slot <= 4'h0;
            sclk_o <= 1'b0;
            mosi_o <= 1'b0;
        end else if (load_req) begin
            tx_sh <= load_byte;
            slot <= 4'h0;
            busy <= 1'b1;
            sclk_o <= 1'b0;
        end else if (busy && half_tick) begin
            slot <= slot + 4'h1;
            sclk_o <= ~slot[0];
            if (!slot[0]) begin
                mosi_o <= tx_sh[7];
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
            if (slot == 4'hF) begin
                busy <= 1'b0;
            end
        end else if (!busy) begin
            sclk_o <= 1'b0;
            mosi_o <= 1'b0;
        end
    end
endmodule

// [rtl/mtd_regs.vh]
// Constants for the Manchester telegram decoder: register map, fields, reset values, timing.
// Assumes a single 10 MHz clock and an APB master with 32-bit data.
// Summary of operation
// - Bit value is first-half level
// - Framing runs only with data manager enabled
// - ID matches stored configuration byte
// - Complemented ID byte also matches
// - Header is 0110 or complement
// - First data bit follows header directly
// - One pair of equal half-bits ends message
// - Complemented header inverts data until end
// - Wake pin high forces run mode
// - Run/sleep by pin or internal timer
// - Sleep keeps configuration unchanged
// - Reset loads working default configuration
// - Raw output when disabled, serial when enabled
// - Header mode only with data manager enabled
// - Timer cycling stays running after ID only
// - Serial master when config pin high
// - Final partial output byte is padded
`ifndef MTD_REGS_VH
`define MTD_REGS_VH
`define MTD_ADDR_CFG1 12'h000
`define MTD_ADDR_CFG2 12'h004
`define MTD_ADDR_RATE 12'h008
`define MTD_ADDR_STAT 12'h00C
`define MTD_CFG1_RESET 8'hD4
`define MTD_CFG2_RESET 8'h00
`define MTD_RATE_RESET 16'h0410
`define MTD_BIT_HDR 0
`define MTD_BIT_DATA_MGR 1
`define MTD_BIT_SR0 2
`define MTD_BIT_SR1 3
`define MTD_BIT_SOE 4
`define MTD_BIT_MOD 5
`define MTD_HDR_WORD 4'h6
`define MTD_TSTROBE_US 1000
`define MTD_CLK_MHZ 10
`define MTD_TSTROBE_CYC (`MTD_TSTROBE_US * `MTD_CLK_MHZ)
`endif

// [dv/mtd_decoder_assertions.sv]
// Checker for the telegram decoder ports.
// Assumes configuration changes only through APB writes.
`timescale 1ns/1ns
module mtd_decoder_chk (
    // Clock and reset.
    input wire clk_i,
    input wire rst_n_i,
    // APB.
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    // Pins.
    input wire demod_output_pin_i,
    input wire wake_pin_i,
    input wire config_mode_pin_i,
    input wire mosi_o,
    input wire sclk_o,
    input wire run_mode_o
);
    reg [7:0] c1;
    reg [7:0] c2;
    wire wr = psel_i && penable_i && pwrite_i && pready_o;
    // Shadow copies of the two configuration bytes.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            c1 <= 8'hD4;
            c2 <= 8'h00;
        end else if (wr && paddr_i == 12'h000) begin
            c1 <= pwdata_i[7:0];
        end else if (wr && paddr_i == 12'h004) begin
            c2 <= pwdata_i[7:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wake_run_a: assert property (wake_pin_i |-> ##[1:2] run_mode_o)
        else $error("wake pin did not force run");
    raw_pass_a: assert property ($past(rst_n_i) && !c1[1] && !$past(c1[1])
        |-> mosi_o == $past(demod_output_pin_i)) else $error("raw data not passed");
    sclk_quiet_a: assert property (!c1[1] && !$past(c1[1]) |-> !sclk_o)
        else $error("clock while disabled");
    sclk_master_a: assert property (sclk_o |-> c1[1] && config_mode_pin_i)
        else $error("clock without master mode");
    sclk_width_a: assert property ($rose(sclk_o) |=> sclk_o[*3])
        else $error("clock pulse too short");
    strobe_off_a: assert property ((!c1[4] && !wake_pin_i)[*3] |-> !run_mode_o)
        else $error("run without wake pin");
    reset_dflt_a: assert property ($rose(rst_n_i) |-> run_mode_o && !sclk_o && !mosi_o)
        else $error("bad state after reset");
    cfg_hold_a: assert property (psel_i && penable_i && !pwrite_i
        |-> (paddr_i != 12'h000 || prdata_o[7:0] == c1)
        && (paddr_i != 12'h004 || prdata_o[7:0] == c2)) else $error("configuration lost");
endmodule
bind mtd_decoder mtd_decoder_chk chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .demod_output_pin_i(demod_output_pin_i), .wake_pin_i(wake_pin_i),
    .config_mode_pin_i(config_mode_pin_i), .mosi_o(mosi_o), .sclk_o(sclk_o),
    .run_mode_o(run_mode_o));

// [dv/mtd_tx_model.sv]
// Remote transmitter model driving the demodulated data line.
// Assumes the bench calls its tasks; the line changes just after rising edges.
`timescale 1ns/1ns
module mtd_tx_model #(
    parameter HALF = 16
) (
    // Clock.
    input wire clk_i,
    // Demodulated line.
    output logic line_o
);
    initial line_o = 1'b0;
    task hold(input logic v, input int n);
        @(posedge clk_i);
        line_o <= v;
        repeat (n - 1) @(posedge clk_i);
    endtask
    task mbit(input logic b);
        hold(b, HALF);
        hold(!b, HALF);
    endtask
    task send(input logic [7:0] id, input logic inv, input logic [7:0] d);
        logic [3:0] h;
        h = inv ? 4'h9 : 4'h6;
        hold(1'b1, 2100);
        repeat (4) mbit(1'b0);
        for (int i = 7; i >= 0; i--) mbit(id[i]);
        for (int i = 3; i >= 0; i--) mbit(h[i]);
        for (int i = 7; i >= 0; i--) mbit(d[i]);
        hold(1'b1, 4 * HALF);
        hold(1'b0, HALF);
    endtask
endmodule

// [dv/mtd_decoder_tb.sv]
// Self-checking bench for the telegram decoder.
// Assumes the transmitter model and the bound checker.
`timescale 1ns/1ns
module mtd_decoder_tb;
    localparam HB = 16;
    logic clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic wake_pin_i = 1, config_mode_pin_i = 1, sclk_q = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, rd;
    logic [7:0] d;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, mosi_o, sclk_o, run_mode_o, demod_w;
    int failures = 0, checked = 0, runs;
    logic q[$];
    mtd_decoder #(.TSTROBE_CYC(100)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .demod_output_pin_i(demod_w), .wake_pin_i(wake_pin_i),
        .config_mode_pin_i(config_mode_pin_i), .mosi_o(mosi_o), .sclk_o(sclk_o),
        .run_mode_o(run_mode_o));
    mtd_tx_model #(.HALF(HB)) tx_u (.clk_i(clk_i), .line_o(demod_w));
    initial forever #50 clk_i = ~clk_i;
    // Serial data is captured as the clock falls.
    always @(posedge clk_i) begin
        sclk_q <= sclk_o;
        if (sclk_q && !sclk_o) q.push_back(mosi_o);
    end
    function automatic logic [7:0] want(input logic [7:0] v, input logic inv);
        return inv ? ~v : v;
    endfunction
    function automatic logic [7:0] pack();
        logic [7:0] r = 8'h00;
        for (int i = 0; i < 8 && i < q.size(); i++) r[7 - i] = q[i];
        return r;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= v;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task end_sim;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk_i);
        failures++;
        end_sim;
    end
    initial begin
        d = 8'($urandom(24116));
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        apb(1'b0, 12'h000, 0);
        chk(rd, 32'h000000D4);
        apb(1'b0, 12'h008, 0);
        chk(rd, 32'h00000410);
        apb(1'b0, 12'h010, 0);
        chk(rd, 32'h00000000);
        $display("test defaults done");
        for (int i = 0; i < 40; i++) begin
            d[0] = 1'($urandom);
            tx_u.hold(d[0], 1);
            @(posedge clk_i);
            @(negedge clk_i);
            chk(32'({sclk_o, mosi_o}), 32'({1'b0, d[0]}));
        end
        $display("test raw done");
        apb(1'b1, 12'h008, HB);
        apb(1'b1, 12'h004, 32'h000000C3);
        apb(1'b1, 12'h000, 32'h000000C7);
        wake_pin_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk(32'(run_mode_o), 32'h0);
        apb(1'b0, 12'h004, 0);
        chk(rd, 32'h000000C3);
        wake_pin_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(32'(run_mode_o), 32'h1);
        apb(1'b1, 12'h000, 32'h000000D7);
        wake_pin_i <= 1'b0;
        repeat (800) @(posedge clk_i);
        runs = 0;
        repeat (800) @(posedge clk_i) runs += int'(run_mode_o);
        chk(runs, 100);
        wake_pin_i <= 1'b1;
        $display("test wake done");
        for (int t = 0; t < 5; t++) begin
            d = 8'($urandom);
            config_mode_pin_i <= (t != 4);
            q.delete();
            tx_u.send(t[0] ? 8'h3C : 8'hC3, t[1], d);
            repeat (40 * HB) @(posedge clk_i);
            if (t == 4) chk(q.size(), 0);
            else chk(32'({q.size() >= 8, pack()}), 32'({1'b1, want(d, t[1])}));
            $display("test telegram %0d done", t);
        end
        end_sim;
    end
endmodule
